// *** rtl/wwdt_core.sv ***
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wwdt_core (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins
	input  wire logic        slck,
	input  wire logic        debug_state,
	input  wire logic        idle_state,
	// Fault and interrupt
	output logic             fault_to_reset,
	output logic             processor_only_reset_select,
	output logic             watchdog_irq
);
	import wwdt_pkg::*;

	wwdt_tick_if tk ();

	logic [31:0]           watchdog_mode_setup_q;
	logic                  mode_written_q;
	logic [WWDT_CNT_W-1:0] count_q;
	logic                  underflow_flag_q;
	logic                  window_error_flag_q;
	logic                  fault_q;
	logic [1:0]            dbg_sync_q;
	logic [1:0]            idle_sync_q;
	logic [WWDT_CNT_W-1:0] reload_count_field;
	logic [WWDT_CNT_W-1:0] restart_window_delta;
	logic                  access;
	logic                  cmd_wr;
	logic                  key_ok;
	logic                  restart_req;
	logic                  window_err;
	logic                  restart_ok;
	logic                  mode_wr;
	logic                  flags_rd;
	logic                  halted;
	logic                  underflow_ev;
	logic [31:0]           prdata_q;
	logic [31:0]           flags_now;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_sync_q  <= 2'h0;
			idle_sync_q <= 2'h0;
		end else begin
			dbg_sync_q  <= {dbg_sync_q[0], debug_state};
			idle_sync_q <= {idle_sync_q[0], idle_state};
		end
	end

	// ************************************************************
	// APB decode
	// ************************************************************
	assign reload_count_field   = watchdog_mode_setup_q[WWDT_RELOAD_LSB +: WWDT_CNT_W];
	assign restart_window_delta = watchdog_mode_setup_q[WWDT_DELTA_LSB +: WWDT_CNT_W];
	assign access      = psel && penable;
	assign cmd_wr      = access && pwrite && (paddr == WWDT_OFF_CMD);
	assign key_ok      = (pwdata[WWDT_KEY_LSB +: 8] == WWDT_KEY); // R9 R17
	assign restart_req = cmd_wr && key_ok && pwdata[WWDT_RESTART_BIT]; // R9
	// The window check ignores the disable bit, so a stray restart is caught while disabled.
	assign window_err  = restart_req && (count_q > restart_window_delta); // R11 R12
	assign restart_ok  = restart_req && !window_err;
	assign mode_wr     = access && pwrite && (paddr == WWDT_OFF_MODE) && !mode_written_q; // R6
	assign flags_rd    = access && !pwrite && (paddr == WWDT_OFF_FLAGS);

	assign pready  = 1'b1;
	assign pslverr = psel && penable && (paddr != WWDT_OFF_CMD) &&
		(paddr != WWDT_OFF_MODE) && (paddr != WWDT_OFF_FLAGS);

	// Read data is loaded in the setup cycle so that the access cycle returns a flop; an event
	// on that same edge is folded in, so a flag raised there is reported and not lost.
	always_comb begin
		flags_now = 32'h00000000;
		flags_now[WWDT_UNF_BIT] = underflow_flag_q || underflow_ev;
		flags_now[WWDT_ERR_BIT] = window_error_flag_q || window_err;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				WWDT_OFF_MODE: begin
					prdata_q <= pwrite ? 32'h00000000 : watchdog_mode_setup_q;
				end
				WWDT_OFF_FLAGS: begin
					prdata_q <= pwrite ? 32'h00000000 : flags_now;
				end
				default: begin
					prdata_q <= 32'h00000000;
				end
			endcase
		end
	end

	assign prdata = prdata_q;

	// ************************************************************
	// Mode register, writable once per reset
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_mode_setup_q <= WWDT_MODE_RST; // R3 R4
			mode_written_q        <= 1'b0;
		end else if (mode_wr) begin
			watchdog_mode_setup_q <= pwdata; // R6
			mode_written_q        <= 1'b1; // R6
		end
	end

	// ************************************************************
	// Down counter
	// ************************************************************
	// The divider freezes with the counter, so a halt does not shorten the period that follows.
	assign halted = watchdog_mode_setup_q[WWDT_DIS_BIT] || // R5
		(dbg_sync_q[1] && watchdog_mode_setup_q[WWDT_DBGHLT_BIT]) || // R16 R18
		(idle_sync_q[1] && watchdog_mode_setup_q[WWDT_IDLEHLT_BIT]); // R16 R18

	assign tk.run     = !halted;
	assign tk.restart = restart_ok || mode_wr; // R7 R8
	assign underflow_ev = tk.tick && (count_q == 12'h000); // R20

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= WWDT_CNT_RST; // R3 R4
		end else if (mode_wr) begin
			count_q <= pwdata[WWDT_RELOAD_LSB +: WWDT_CNT_W]; // R7
		end else if (restart_ok) begin
			count_q <= reload_count_field; // R8
		end else if (underflow_ev) begin
			// The counter re-arms from the reload value so later underflows keep flagging.
			count_q <= reload_count_field;
		end else if (tk.tick) begin
			count_q <= count_q - 12'h001; // R1 R2
		end
	end

	wwdt_tick_gen u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.slck    (slck),
		.tk      (tk.div)
	);

	// ************************************************************
	// Sticky flags and fault; a new event wins over the clearing read
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			underflow_flag_q <= 1'b0; // R14 R15
		end else if (underflow_ev) begin
			underflow_flag_q <= 1'b1; // R10
		end else if (flags_rd) begin
			underflow_flag_q <= 1'b0; // R15
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_error_flag_q <= 1'b0; // R14 R15
		end else if (window_err) begin
			window_error_flag_q <= 1'b1; // R11
		end else if (flags_rd) begin
			window_error_flag_q <= 1'b0; // R15
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 1'b0; // R15
		end else if ((underflow_ev && watchdog_mode_setup_q[WWDT_RSTEN_BIT]) || window_err) begin
			fault_q <= 1'b1; // R10 R11
		end else if (flags_rd) begin
			fault_q <= 1'b0; // R15
		end
	end

	assign fault_to_reset = fault_q;
	assign processor_only_reset_select = watchdog_mode_setup_q[WWDT_PROC_BIT]; // R19
	assign watchdog_irq = watchdog_mode_setup_q[WWDT_FIEN_BIT] &&
		(underflow_flag_q || window_error_flag_q); // R13

	// ************************************************************
	// Checks
	// ************************************************************
	key_guard_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(cmd_wr && !key_ok && !window_error_flag_q) |=> !window_error_flag_q)
		else $error("unkeyed control write had an effect");

	mode_once_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(mode_written_q && access && pwrite && paddr == WWDT_OFF_MODE)
		|=> (watchdog_mode_setup_q == $past(watchdog_mode_setup_q)))
		else $error("second mode write was taken");

	underflow_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(tk.tick && count_q == 12'h000)
		|=> underflow_flag_q && (fault_q || !$past(watchdog_mode_setup_q[WWDT_RSTEN_BIT])))
		else $error("underflow did not set the flag");

	window_err_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		(restart_req && count_q > restart_window_delta && !tk.tick)
		|=> window_error_flag_q && fault_q && count_q == $past(count_q))
		else $error("out of window restart did not fault");

	restart_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(restart_req && count_q <= restart_window_delta && !mode_wr)
		|=> (count_q == $past(reload_count_field)) &&
		(window_error_flag_q == $past(window_error_flag_q)))
		else $error("restart did not reload the counter");

	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
		watchdog_irq |-> (watchdog_mode_setup_q[WWDT_FIEN_BIT] &&
		(underflow_flag_q || window_error_flag_q)))
		else $error("interrupt raised without enabled flag");

	read_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(flags_rd && !underflow_ev && !window_err)
		|=> !underflow_flag_q && !window_error_flag_q && !fault_to_reset && !watchdog_irq)
		else $error("status read did not clear flags");

	halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R5 R18
		(halted && !tk.restart) |=> (count_q == $past(count_q)))
		else $error("counter moved while halted");

	count_step_a: assert property (@(posedge pclk) disable iff (!presetn) // R1 R2
		(tk.tick && count_q != 12'h000 && !tk.restart)
		|=> (count_q == $past(count_q) - 12'h001))
		else $error("counter did not step down by one");

	mode_reload_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
		mode_wr |=> (count_q == $past(pwdata[WWDT_RELOAD_LSB +: WWDT_CNT_W])) &&
		(watchdog_mode_setup_q == $past(pwdata)))
		else $error("mode write did not reload the counter");

	unkeyed_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(cmd_wr && !key_ok && !tk.tick)
		|=> (count_q == $past(count_q)))
		else $error("unkeyed control write moved the counter");

	underflow_rearm_a: assert property (@(posedge pclk) disable iff (!presetn) // R20
		underflow_ev
		|=> (count_q == $past(reload_count_field)))
		else $error("counter did not re-arm after underflow");

	unf_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(underflow_flag_q && !flags_rd)
		|=> underflow_flag_q)
		else $error("underflow flag dropped without a read");

	err_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(window_error_flag_q && !flags_rd)
		|=> window_error_flag_q)
		else $error("error flag dropped without a read");

	fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		(fault_q && !flags_rd)
		|=> fault_q)
		else $error("fault dropped without a read");

	err_disabled_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
		(restart_req && watchdog_mode_setup_q[WWDT_DIS_BIT] && count_q > restart_window_delta)
		|=> window_error_flag_q && fault_q)
		else $error("restart while disabled was not an error");

	window_free_a: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(restart_req && restart_window_delta >= reload_count_field && count_q <= reload_count_field)
		|=> (window_error_flag_q == $past(window_error_flag_q)))
		else $error("restart with open window raised an error");

	idle_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // R16 R18
		(idle_sync_q[1] && watchdog_mode_setup_q[WWDT_IDLEHLT_BIT] && !tk.restart)
		|=> (count_q == $past(count_q)))
		else $error("counter moved in idle with idle halt set");

	debug_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // R16 R18
		(dbg_sync_q[1] && watchdog_mode_setup_q[WWDT_DBGHLT_BIT] && !tk.restart)
		|=> (count_q == $past(count_q)))
		else $error("counter moved in debug with debug halt set");

	read_report_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
		flags_rd |-> (prdata[WWDT_UNF_BIT] == underflow_flag_q) &&
		(prdata[WWDT_ERR_BIT] == window_error_flag_q))
		else $error("status read returned stale flags");

	mode_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(access && !pwrite && paddr == WWDT_OFF_MODE)
		|-> (prdata == watchdog_mode_setup_q))
		else $error("mode read returned wrong data");

	halt_no_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // R5 R16
		halted |-> !tk.tick)
		else $error("divider ticked while halted");
endmodule
`default_nettype wire

// *** rtl/wwdt_pkg.sv ***
// Functional notes
// R1: The watchdog is a 12-bit down counter loaded from the reload count field.
// R2: The counter steps down once per tick of a slow clock divided by 128.
// R3: After reset the reload field reads 0xFFF and fault reset is enabled.
// R4: A processor reset reloads the watchdog with its initial values.
// R5: Setting the disable bit stops the watchdog counter.
// R6: Only the first mode write after reset is taken; later ones are ignored.
// R7: A mode write reloads the down counter with the new value and restarts it.
// R8: A keyed restart reloads the counter and restarts the divide-by-128 divider.
// R9: Control writes without the correct key have no effect.
// R10: Underflow sets the underflow flag and, if reset enabled, the fault.
// R11: A restart above the window delta is an error, even when disabled.
// R12: A delta at or above the reload value allows restarts anywhere.
// R13: The flags raise the interrupt only while fault interrupt enable is set.
// R14: A watchdog reset clears the processor, the watchdog and both flags.
// R15: Reset or a status read clears flags, interrupt and fault signal.
// R16: In debug or idle state the counter halts as the halt bits select.
// R17: Software puts 0xA5 in bits 31 to 24 of the control register.
// R18: Debug halt at 1 stops counting in debug state; idle halt likewise.
// R19: With reset enabled, the processor-only bit selects processor or all resets.
// R20: A divider tick while the counter is zero counts as an underflow.
package wwdt_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [11:0] WWDT_OFF_CMD   = 12'h000;
	localparam logic [11:0] WWDT_OFF_MODE  = 12'h004;
	localparam logic [11:0] WWDT_OFF_FLAGS = 12'h008;

	// ************************************************************
	// Field layout and reset values
	// ************************************************************
	localparam int          WWDT_CNT_W       = 12;
	localparam int          WWDT_RELOAD_LSB  = 0;
	localparam int          WWDT_FIEN_BIT    = 12;
	localparam int          WWDT_RSTEN_BIT   = 13;
	localparam int          WWDT_PROC_BIT    = 14;
	localparam int          WWDT_DIS_BIT     = 15;
	localparam int          WWDT_DELTA_LSB   = 16;
	localparam int          WWDT_DBGHLT_BIT  = 28;
	localparam int          WWDT_IDLEHLT_BIT = 29;
	localparam int          WWDT_KEY_LSB     = 24;
	localparam int          WWDT_RESTART_BIT = 0;
	localparam int          WWDT_UNF_BIT     = 0;
	localparam int          WWDT_ERR_BIT     = 1;
	localparam logic [31:0] WWDT_MODE_RST    = 32'h3fff2fff;
	localparam logic [11:0] WWDT_CNT_RST     = 12'hfff;
	localparam logic [7:0]  WWDT_KEY         = 8'ha5;

	// ************************************************************
	// Slow clock divider
	// ************************************************************
	localparam int          WWDT_DIV         = 128;
	localparam logic [6:0]  WWDT_DIV_LAST    = 7'(WWDT_DIV - 1);

endpackage

// *** rtl/wwdt_tick_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module wwdt_tick_gen (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Slow clock pin
	input  wire logic slck,
	// Core side
	wwdt_tick_if.div  tk
);
	import wwdt_pkg::*;

	logic [2:0] sync_q;
	logic [6:0] div_q;
	logic       slow_edge;

	// The slow clock is sampled as a plain input; only its synchronised copy feeds the edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], slck};
		end
	end

	assign slow_edge = sync_q[1] & ~sync_q[2];

	// ************************************************************
	// Divide by 128, cleared by every restart
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 7'h00;
		end else if (tk.restart) begin
			div_q <= 7'h00; // R8
		end else if (tk.run && slow_edge) begin
			div_q <= div_q + 7'h01; // R2
		end
	end

	assign tk.tick = tk.run && slow_edge && !tk.restart && (div_q == WWDT_DIV_LAST); // R2

	tick_period_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
		tk.tick |=> (div_q == 7'h00))
		else $error("divider did not wrap after a tick");

	div_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
		tk.restart |=> (div_q == 7'h00))
		else $error("restart did not clear the divider");
endmodule
`default_nettype wire

// *** rtl/wwdt_tick_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface wwdt_tick_if;
	logic restart;
	logic run;
	logic tick;

	modport core (output restart, output run, input tick);
	modport div  (input restart, input run, output tick);
endinterface
`default_nettype wire

// *** tb/windowed_watchdog_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer_tb;
	import wwdt_pkg::*;
	logic pclk = 1'b0, por_n = 1'b0, arm = 1'b0, slck = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic debug_state = 1'b0, idle_state = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, rd, m, lf = 32'haa70ad08;
	logic pready, pslverr, fault, proc_sel, irq, rst_n, lastp, er;
	logic [3:0] hits;
	logic [7:0] key;
	int n_errors = 0, compares = 0, cyc = 0;

	always #20 pclk = ~pclk;

	wwdt_core wwdt_core_i (.pclk(pclk), .presetn(por_n & rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .slck(slck),
		.debug_state(debug_state), .idle_state(idle_state),
		.fault_to_reset(fault), .processor_only_reset_select(proc_sel),
		.watchdog_irq(irq));
	wwdt_rst_model wwdt_rst_model_i (.pclk(pclk), .por_n(por_n), .arm(arm),
		.fault_to_reset(fault), .processor_only_reset_select(proc_sel),
		.rst_n(rst_n), .hits_q(hits), .last_proc_q(lastp));

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] mode_w(input logic [11:0] v, input logic [11:0] dl,
		input logic [3:0] f, input logic [1:0] h);
		return {2'b00, h, dl, f, v};
	endfunction

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Slow clock edges, eight pclk per period, still between bursts.
	task automatic slk(input int n);
		repeat (n) begin
			slck <= 1'b1;
			repeat (4) @(posedge pclk);
			slck <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask

	task automatic final_report;
		$display("n_errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			final_report();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (16) @(posedge pclk);
		por_n <= 1'b1;
		@(posedge pclk);
		apb(1'b0, WWDT_OFF_MODE, 32'h0);
		chk(rd, WWDT_MODE_RST);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, er}, 32'h1);
		m = mode_w(12'h003, 12'h001, 4'b0111, 2'b11);
		apb(1'b1, WWDT_OFF_MODE, m);
		apb(1'b1, WWDT_OFF_MODE, mode_w(12'h0ff, 12'h0ff, 4'b0000, 2'b00));
		apb(1'b0, WWDT_OFF_MODE, 32'h0);
		chk(rd, m);
		chk({31'h0, proc_sel}, 32'h1);
		lf = lfsr(lf);
		key = (lf[7:0] == WWDT_KEY) ? 8'h5a : lf[7:0];
		apb(1'b1, WWDT_OFF_CMD, {key, lf[23:1], 1'b1});
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, WWDT_OFF_CMD, 32'ha5000001);
		chk({31'h0, fault}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h2);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, fault, irq}, 32'h0);
		debug_state <= 1'b1;
		slk(256);
		debug_state <= 1'b0;
		idle_state  <= 1'b1;
		slk(256);
		idle_state  <= 1'b0;
		slk(300);
		apb(1'b1, WWDT_OFF_CMD, 32'ha5000001);
		slk(511);
		chk({31'h0, fault}, 32'h0);
		arm <= 1'b1;
		slk(1);
		repeat (8) @(posedge pclk);
		chk({28'h0, hits}, 32'h1);
		chk({31'h0, lastp}, 32'h1);
		arm <= 1'b0;
		apb(1'b0, WWDT_OFF_MODE, 32'h0);
		chk(rd, WWDT_MODE_RST);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, WWDT_OFF_CMD, 32'ha5000001);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, WWDT_OFF_MODE, mode_w(12'h002, 12'h000, 4'b1000, 2'b00));
		chk({31'h0, proc_sel}, 32'h0);
		apb(1'b1, WWDT_OFF_CMD, 32'ha5000001);
		chk({31'h0, fault}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h2);
		slk(400);
		apb(1'b0, WWDT_OFF_FLAGS, 32'h0);
		chk(rd, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire

// *** tb/wwdt_rst_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wwdt_rst_model (
	// Clock and power-on reset
	input  wire logic       pclk,
	input  wire logic       por_n,
	// Watchdog side
	input  wire logic       arm,
	input  wire logic       fault_to_reset,
	input  wire logic       processor_only_reset_select,
	// Reset out and record
	output logic            rst_n,
	output logic [3:0]      hits_q,
	output logic            last_proc_q
);
	logic [2:0] cnt_q;

	// The pulse outlasts the fault, so one fault gives one reset.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			cnt_q       <= 3'h0;
			hits_q      <= 4'h0;
			last_proc_q <= 1'b0;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end else if (arm && fault_to_reset) begin
			cnt_q       <= 3'h4;
			hits_q      <= hits_q + 4'h1;
			last_proc_q <= processor_only_reset_select;
		end
	end

	assign rst_n = (cnt_q == 3'h0);
endmodule
`default_nettype wire
